// ### design/flash_status_pkg.sv
// Constants for the serial flash status register block.
// Assumes an SPI mode 0/3 host and a 100 MHz system clock beside the link clock.
package flash_status_pkg;
  // Command codes
  localparam logic [7:0] CMD_READ_STATUS  = 8'h05;
  localparam logic [7:0] CMD_WRITE_STAT1  = 8'h01;
  localparam logic [7:0] CMD_WRITE_STAT2  = 8'h31;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DIS    = 8'h04;
  localparam logic [7:0] CMD_PROTECT      = 8'h36;
  localparam logic [7:0] CMD_UNPROTECT    = 8'h39;
  localparam logic [7:0] CMD_LOCKDOWN     = 8'h33;
  localparam logic [7:0] CMD_FREEZE       = 8'h34;
  localparam logic [7:0] CMD_SOFT_RESET   = 8'hf0;
  // Byte one field positions
  localparam int B1_LOCK   = 7;
  localparam int B1_ERR    = 5;
  localparam int B1_PIN    = 4;
  localparam int B1_SWP_HI = 3;
  localparam int B1_SWP_LO = 2;
  localparam int B1_WEL    = 1;
  localparam int B_BUSY    = 0;
  // Byte two field positions
  localparam int B2_SOFT_RESET_PERMIT   = 4;
  localparam int B2_SLE    = 3;
  // Software protection codes
  localparam logic [1:0] SWP_NONE = 2'h0;
  localparam logic [1:0] SWP_SOME = 2'h1;
  localparam logic [1:0] SWP_ALL  = 2'h3;
  // Reset values
  localparam logic       LOCK_RESET = 1'h0;
  localparam logic       SOFT_RESET_PERMIT_RESET = 1'h0;
  localparam logic       SLE_RESET  = 1'h0;
  localparam logic       WEL_RESET  = 1'h0;
  localparam logic       ERR_RESET  = 1'h0;
  localparam logic [1:0] SWP_RESET  = SWP_ALL;
  // Link transaction kinds handed to the system domain
  typedef enum logic [3:0] {
    OP_NONE    = 4'h0,
    OP_WREN    = 4'h1,
    OP_WRDI    = 4'h2,
    OP_WSTAT1  = 4'h3,
    OP_WSTAT2  = 4'h4,
    OP_PROTECT = 4'h5,
    OP_UNPROT  = 4'h6,
    OP_LOCKDN  = 4'h7,
    OP_FREEZE  = 4'h8,
    OP_SRESET  = 4'h9
  } link_op_e;
endpackage

// ### design/status_sync.sv
// Two flip-flop level synchroniser, parameterised width.
// Assumes the input is quasi-static relative to the destination clock.
`timescale 1ns/1ps
module status_sync #(
  parameter int WIDTH = 1
) (
  // Destination domain
  input  wire logic             clk,
  input  wire logic             rst,
  // Level in and out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage <= '0;
      dout  <= '0;
    end else begin
      stage <= din;
      dout  <= stage;
    end
  end
endmodule

// ### design/flash_status_regs.sv
// What this block does
// (RULE1) Status readable at any time, even busy
// (RULE2) Command 05h then status bits on output
// (RULE3) Bytes repeat alternately with fresh values
// (RULE4) Bit 0 of both bytes is busy
// (RULE5) Host reads four bytes at high clock
// (RULE6) Select high ends read, output released
// (RULE7) Byte one bit 7 is protection lock
// (RULE8) Byte one bit 5 is error flag
// (RULE9) Byte one bit 4 mirrors protect pin
// (RULE10) Byte one bits 3:2 report protection
// (RULE11) Byte one bit 1 is write latch
// (RULE12) Byte two bit 4 permits soft reset
// (RULE13) Byte two bit 3 permits lockdown
// (RULE14) Write one changes only bit 7
// (RULE15) Write two changes bits 4, 3 only
// (RULE16) Lock set ignores sector protect commands
// (RULE17) Lock set blocks global protect/unprotect
// (RULE18) Lock clear processes protection requests normally
// (RULE19) Lock clears at power-up, survives reset
// (RULE20) Pin asserted allows only lock set
// (RULE21) Host deasserts pin before clearing lock
// (RULE22) Write latch gates protected commands, resets 0
// (RULE23) Freeze forces lockdown permit to zero
// (RULE24) Error flag updated only by real operations
// (RULE25) MSB first, shifted on falling edge
//
// Status register bank of a serial flash: SPI front end on the link clock,
// register state on the system clock. Commands cross via a toggle handshake.
`timescale 1ns/1ps
module flash_status_regs
  import flash_status_pkg::*;
(
  // System clock and reset
  input  wire logic CLK,
  input  wire logic SYS_RST,
  // Serial link
  input  wire logic SCK,
  input  wire logic CS_N,
  input  wire logic SI,
  output logic      SO,
  output logic      SO_OE,
  // Device pins and engine status
  input  wire logic WP_N,
  input  wire logic ENGINE_BUSY,
  input  wire logic ENGINE_DONE,
  input  wire logic ENGINE_FAIL,
  input  wire logic ENGINE_ABORTED,
  // Protection engine requests and state
  input  wire logic [1:0] PROT_STATE,
  output logic      SECTOR_PROTECT,
  output logic      SECTOR_UNPROTECT,
  output logic      GLOBAL_PROTECT,
  output logic      GLOBAL_UNPROTECT,
  output logic      LOCKDOWN_REQ,
  output logic      FREEZE_REQ,
  output logic      SOFT_RESET_REQ
);
  import flash_status_pkg::*;

  // ---------------- Link domain ----------------
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
    logic [3:0] bitcnt;
    logic       cmd_done;
    logic       data_done;
    logic       odd_bits;
    logic       rd_active;
  } lnk_s;

  // Falling-edge and frame-end state live apart: each has a process of its own
  logic       byte_sel;
  logic [7:0] shreg;
  logic       req_tgl;
  logic [3:0] req_op;
  logic [7:0] req_data;

  lnk_s lnk, next_lnk;
  logic [7:0] live_one;
  logic [7:0] live_two;
  logic       so_bit;
  logic       cs_rst;
  logic       end_frame;

  assign cs_rst = SYS_RST | CS_N; // Frame state cleared by select itself

  // Decode a finished command/data pair into a request kind
  function automatic logic [3:0] decode_op(input logic [7:0] c, input logic has_data);
    logic [3:0] r;
    r = OP_NONE;
    case (c)
      CMD_WRITE_ENABLE: r = OP_WREN;
      CMD_WRITE_DIS:    r = OP_WRDI;
      CMD_FREEZE:       r = OP_FREEZE;
      CMD_SOFT_RESET:   r = OP_SRESET;
      // An aborted status write still drops the write latch
      CMD_WRITE_STAT1:  r = has_data ? OP_WSTAT1 : OP_WRDI;
      CMD_WRITE_STAT2:  r = has_data ? OP_WSTAT2 : OP_WRDI;
      CMD_PROTECT:      r = OP_PROTECT;
      CMD_UNPROTECT:    r = OP_UNPROT;
      CMD_LOCKDOWN:     r = OP_LOCKDN;
      default:          r = OP_NONE;
    endcase
    return r;
  endfunction

  // Shift-in on rising edge; frame state resets while select is high
  always_comb begin
    next_lnk = lnk;
    if (!lnk.cmd_done) begin
      next_lnk.cmd = {lnk.cmd[6:0], SI};
    end else if (!lnk.data_done) begin
      next_lnk.data = {lnk.data[6:0], SI};
    end
    next_lnk.bitcnt = lnk.bitcnt + 4'h1;
    next_lnk.odd_bits = 1'b1;
    if (lnk.bitcnt == 4'h7) begin
      next_lnk.bitcnt = 4'h0;
      next_lnk.odd_bits = 1'b0;
      if (!lnk.cmd_done) begin
        next_lnk.cmd_done = 1'b1;
        if ({lnk.cmd[6:0], SI} == CMD_READ_STATUS) begin
          next_lnk.rd_active = 1'b1; // RULE2
        end
      end else begin
        next_lnk.data_done = 1'b1;
      end
    end
  end

  always_ff @(posedge SCK or posedge cs_rst) begin
    if (cs_rst) begin
      lnk.cmd       <= 8'h00;
      lnk.data      <= 8'h00;
      lnk.bitcnt    <= 4'h0;
      lnk.cmd_done  <= 1'b0;
      lnk.data_done <= 1'b0;
      lnk.odd_bits  <= 1'b0;
      lnk.rd_active <= 1'b0;
    end else begin
      lnk.cmd       <= next_lnk.cmd;
      lnk.data      <= next_lnk.data;
      lnk.bitcnt    <= next_lnk.bitcnt;
      lnk.cmd_done  <= next_lnk.cmd_done;
      lnk.data_done <= next_lnk.data_done;
      lnk.odd_bits  <= next_lnk.odd_bits;
      lnk.rd_active <= next_lnk.rd_active;
    end
  end

  // Output shifter on the falling edge, MSB first; reload at each byte start
  always_ff @(negedge SCK or posedge cs_rst) begin
    if (cs_rst) begin
      shreg    <= 8'h00;
      byte_sel <= 1'b0;
    end else if (lnk.rd_active) begin
      if (lnk.bitcnt == 4'h0) begin
        shreg    <= byte_sel ? live_two : live_one; // RULE3 RULE4
        byte_sel <= ~byte_sel; // RULE3
      end else begin
        shreg <= {shreg[6:0], 1'b0}; // RULE25
      end
    end
  end

  assign so_bit = shreg[7];
  assign SO     = so_bit;
  assign SO_OE  = lnk.rd_active & ~CS_N; // RULE6

  // Frame end: latch the request on the rising edge of select. Writes need
  // whole bytes; a partial byte drops the data so the op aborts in decode.
  assign end_frame = CS_N;
  always_ff @(posedge end_frame or posedge SYS_RST) begin
    if (SYS_RST) begin
      req_tgl  <= 1'b0;
      req_op   <= OP_NONE;
      req_data <= 8'h00;
    end else if (lnk.cmd_done) begin
      req_tgl  <= ~req_tgl;
      req_op   <= decode_op(lnk.cmd, lnk.data_done & ~lnk.odd_bits);
      req_data <= lnk.data;
    end
  end

  // ---------------- System domain ----------------
  typedef struct packed {
    logic       lock;
    logic       err;
    logic       write_latch_flag;
    logic       soft_reset_permit;
    logic       lockdown_permit;
    logic       frozen;
    logic       tgl_seen;
    logic       sp;
    logic       su;
    logic       gp;
    logic       gu;
    logic       ld;
    logic       fz;
    logic       sr;
  } sys_s;

  sys_s st, next_st;
  logic       tgl_sync;
  logic       pin_n_sync;
  logic       busy_sync;
  logic [3:0] op_sys;
  logic [7:0] data_sys;
  logic       new_op;

  status_sync #(.WIDTH(3)) u_sync (
    .clk  (CLK),
    .rst  (SYS_RST),
    .din  ({req_tgl, WP_N, ENGINE_BUSY}),
    .dout ({tgl_sync, pin_n_sync, busy_sync})
  );

  // Op fields are stable once the toggle has crossed
  assign op_sys   = req_op;
  assign data_sys = req_data;
  assign new_op   = tgl_sync ^ st.tgl_seen;

  always_comb begin
    next_st = st;
    next_st.tgl_seen = tgl_sync;
    next_st.sp = 1'b0;
    next_st.su = 1'b0;
    next_st.gp = 1'b0;
    next_st.gu = 1'b0;
    next_st.ld = 1'b0;
    next_st.fz = 1'b0;
    next_st.sr = 1'b0;
    if (ENGINE_DONE && !ENGINE_ABORTED) begin
      next_st.err = ENGINE_FAIL; // RULE24
    end
    if (new_op) begin
      case (op_sys)
        OP_WREN: next_st.write_latch_flag = 1'b1;
        OP_WRDI: next_st.write_latch_flag = 1'b0;
        OP_SRESET: begin
          next_st.sr = st.soft_reset_permit; // RULE12 RULE19
        end
        OP_WSTAT1: begin
          if (st.write_latch_flag) begin
            // Pin asserted: only 0->1 accepted
            if (pin_n_sync || data_sys[B1_LOCK]) begin // RULE20
              next_st.lock = data_sys[B1_LOCK]; // RULE7 RULE14
            end
            if (!st.lock && !(~pin_n_sync && !data_sys[B1_LOCK] && st.lock)) begin // RULE17 RULE18
              next_st.gp = data_sys[5:2] == 4'hf;
              next_st.gu = data_sys[5:2] == 4'h0;
            end
          end
          next_st.write_latch_flag = 1'b0;
        end
        OP_WSTAT2: begin
          if (st.write_latch_flag) begin
            next_st.soft_reset_permit = data_sys[B2_SOFT_RESET_PERMIT]; // RULE15
            next_st.lockdown_permit  = data_sys[B2_SLE] & ~st.frozen; // RULE13 RULE23
          end
          next_st.write_latch_flag = 1'b0;
        end
        OP_PROTECT, OP_UNPROT: begin
          if (st.write_latch_flag && !st.lock) begin // RULE16 RULE18 RULE22
            next_st.sp = (op_sys == OP_PROTECT);
            next_st.su = (op_sys == OP_UNPROT);
          end
          next_st.write_latch_flag = 1'b0;
        end
        OP_LOCKDN, OP_FREEZE: begin
          if (st.write_latch_flag && st.lockdown_permit) begin // RULE22
            next_st.ld = (op_sys == OP_LOCKDN);
            next_st.fz = (op_sys == OP_FREEZE);
            if (op_sys == OP_FREEZE) begin
              next_st.frozen = 1'b1; // RULE23
              next_st.lockdown_permit    = 1'b0;
            end
          end
          next_st.write_latch_flag = 1'b0;
        end
        default: next_st.write_latch_flag = st.write_latch_flag;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st      <= '0;
      st.lock <= LOCK_RESET; // RULE19
      st.err  <= ERR_RESET;
      st.write_latch_flag  <= WEL_RESET; // RULE22
      st.soft_reset_permit <= SOFT_RESET_PERMIT_RESET;
      st.lockdown_permit  <= SLE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Live status words; sampled by the link shifter at byte start, where the
  // system-side bits are quasi-static between rare writes.
  always_comb begin
    live_one = 8'h00;
    live_one[B1_LOCK] = st.lock; // RULE7
    live_one[B1_ERR]  = st.err; // RULE8
    live_one[B1_PIN]  = pin_n_sync; // RULE9
    live_one[B1_SWP_HI:B1_SWP_LO] = PROT_STATE; // RULE10
    live_one[B1_WEL]  = st.write_latch_flag; // RULE11
    live_one[B_BUSY]  = busy_sync; // RULE1 RULE4
    live_two = 8'h00;
    live_two[B2_SOFT_RESET_PERMIT] = st.soft_reset_permit; // RULE12
    live_two[B2_SLE]  = st.lockdown_permit; // RULE13
    live_two[B_BUSY]  = busy_sync; // RULE4
  end

  assign SECTOR_PROTECT   = st.sp;
  assign SECTOR_UNPROTECT = st.su;
  assign GLOBAL_PROTECT   = st.gp;
  assign GLOBAL_UNPROTECT = st.gu;
  assign LOCKDOWN_REQ     = st.ld;
  assign FREEZE_REQ       = st.fz;
  assign SOFT_RESET_REQ   = st.sr;

  // Checks
  chk_lock_blocks_sector: assert property (@(posedge CLK) disable iff (SYS_RST) // RULE16
    st.lock |=> !(st.sp || st.su)) else $error("sector op while locked");
  chk_lock_blocks_global: assert property (@(posedge CLK) disable iff (SYS_RST) // RULE17
    st.lock |=> !(st.gp || st.gu)) else $error("global op while locked");
  chk_pin_holds_lock: assert property (@(posedge CLK) disable iff (SYS_RST) // RULE20
    (st.lock && !pin_n_sync) |=> st.lock) else $error("lock cleared with pin asserted");
  chk_wel_gates_ops: assert property (@(posedge CLK) disable iff (SYS_RST) // RULE22
    !st.write_latch_flag |=> !(st.sp || st.su || st.ld || st.fz)) else $error("op without write latch");
  chk_freeze_kills_sle: assert property (@(posedge CLK) disable iff (SYS_RST) // RULE23
    st.frozen |-> !st.lockdown_permit) else $error("lockdown permit after freeze");
  chk_sr_needs_permit: assert property (@(posedge CLK) disable iff (SYS_RST) // RULE12
    st.sr |-> $past(st.soft_reset_permit)) else $error("soft reset without permit");
  chk_err_on_fail: assert property (@(posedge CLK) disable iff (SYS_RST) // RULE24
    (ENGINE_DONE && !ENGINE_ABORTED) |=> st.err == $past(ENGINE_FAIL)) else $error("error flag wrong");
  chk_so_released: assert property (@(posedge CLK) disable iff (SYS_RST) // RULE6
    CS_N |-> !lnk.rd_active) else $error("read frame alive while deselected");
endmodule

// ### sim/spi_host_model.sv
// SPI mode 0 host model that drives the link of the status register block.
// Assumes the bench calls frame() one at a time; SCK stands still low between frames.
`timescale 1ns/1ps
module spi_host_model
  import flash_status_pkg::*;
(
  // Link pins
  output logic       SCK,
  output logic       CS_N,
  output logic       SI,
  input  wire logic  SO,
  input  wire logic  SO_OE,
  // Bytes received during status reads
  output logic [7:0] rx_byte,
  output logic       rx_toggle
);
  logic last;
  logic so_line;

  // A released line shows the inverse of its last value, so stale data cannot pass
  assign so_line = SO_OE ? SO : ~last;

  initial begin
    SCK = 1'b0;
    CS_N = 1'b1;
    SI = 1'b0;
    last = 1'b0;
    rx_byte = 8'h00;
    rx_toggle = 1'b0;
  end

  task automatic clk_bit(input logic b);
    SI = b;
    #80 SCK = 1'b1;
    rx_byte = {rx_byte[6:0], so_line};
    last = so_line;
    #80 SCK = 1'b0;
  endtask

  // Sends a command, then nbits more bits; status bytes are reported every eight bits
  task automatic frame(input logic [7:0] cmd, input logic [15:0] data, input int nbits);
    // Odd offset keeps link edges off the system clock edges
    #3 CS_N = 1'b0;
    #80;
    for (int i = 7; i >= 0; i--) clk_bit(cmd[i]);
    for (int i = 0; i < nbits; i++) begin
      clk_bit(data[15 - (i % 16)]);
      if (cmd == CMD_READ_STATUS && i % 8 == 7) rx_toggle = ~rx_toggle;
    end
    #80 CS_N = 1'b1;
    SI = ~SI;
  endtask
endmodule

// ### sim/testbench.sv
// Self-checking bench for the flash status register block.
// Assumes the host model owns the link; status bytes are compared in order of arrival.
`timescale 1ns/1ps
module testbench;
  import flash_status_pkg::*;
  logic       CLK = 1'b0;
  logic       SYS_RST = 1'b1;
  logic       WP_N = 1'b1;
  logic       ENGINE_BUSY = 1'b0;
  logic       ENGINE_DONE = 1'b0;
  logic       ENGINE_FAIL = 1'b0;
  logic       ENGINE_ABORTED = 1'b0;
  logic [1:0] PROT_STATE = SWP_ALL;
  wire        sck, cs_n, si, so, so_oe, rx_toggle, gprot, gunprot, sprot;
  wire  [7:0] rx_byte;
  logic [7:0] q[$];
  logic [1:0] swp_tab[3] = '{SWP_NONE, SWP_SOME, SWP_ALL};
  logic       lock = 1'b0;
  logic       err = 1'b0;
  logic       write_latch_flag = 1'b0;
  logic       soft_reset_permit = 1'b0;
  logic       lockdown_permit = 1'b0;
  int         errors = 0;
  int         check_count = 0;
  int         cycles = 0;
  int         gp_cnt = 0;
  int         gu_cnt = 0;
  int         sp_cnt = 0;

  flash_status_regs dut (
    .CLK(CLK), .SYS_RST(SYS_RST), .SCK(sck), .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe),
    .WP_N(WP_N), .ENGINE_BUSY(ENGINE_BUSY), .ENGINE_DONE(ENGINE_DONE), .ENGINE_FAIL(ENGINE_FAIL),
    .ENGINE_ABORTED(ENGINE_ABORTED), .PROT_STATE(PROT_STATE), .SECTOR_PROTECT(sprot), .SECTOR_UNPROTECT(),
    .GLOBAL_PROTECT(gprot), .GLOBAL_UNPROTECT(gunprot), .LOCKDOWN_REQ(), .FREEZE_REQ(), .SOFT_RESET_REQ()
  );

  spi_host_model host (
    .SCK(sck), .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe), .rx_byte(rx_byte), .rx_toggle(rx_toggle)
  );

  always #5 CLK = ~CLK;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge CLK) begin
    gp_cnt += int'(gprot);
    gu_cnt += int'(gunprot);
    sp_cnt += int'(sprot);
    cycles++;
    if (cycles == 60000) begin
      errors++;
      end_of_test();
    end
  end

  // Empty queue guard keeps the time-zero toggle from counting as a byte
  always @(rx_toggle) begin
    if (q.size() != 0) check(rx_byte, q.pop_front(), "status");
  end

  // Two full repetitions of the status word, both with the same freshly drawn busy level
  task automatic rd();
    logic [7:0] b1;
    logic [7:0] b2;
    @(posedge CLK);
    ENGINE_BUSY <= 1'($urandom);
    PROT_STATE <= swp_tab[$urandom % 3];
    repeat (6) @(posedge CLK);
    b1 = {lock, 1'b0, err, WP_N, PROT_STATE, write_latch_flag, ENGINE_BUSY};
    b2 = {3'h0, soft_reset_permit, lockdown_permit, 2'h0, ENGINE_BUSY};
    q.push_back(b1);
    q.push_back(b2);
    q.push_back(b1);
    q.push_back(b2);
    host.frame(CMD_READ_STATUS, 16'h0000, 32);
    #200;
    check(8'(q.size()), 8'h00, "bytes left");
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input int n);
    host.frame(cmd, {d, 8'h00}, n);
    repeat (10) @(posedge CLK);
  endtask

  task automatic eng(input logic f, input logic a);
    @(posedge CLK);
    ENGINE_DONE <= 1'b1;
    ENGINE_FAIL <= f;
    ENGINE_ABORTED <= a;
    @(posedge CLK);
    ENGINE_DONE <= 1'b0;
    ENGINE_FAIL <= 1'b0;
    ENGINE_ABORTED <= 1'b0;
    if (!a) err = f;
    rd();
  endtask

  initial begin
    void'($urandom(68));
    repeat (5) @(posedge CLK);
    SYS_RST <= 1'b0;
    repeat (5) @(posedge CLK);
    rd();
    wr(CMD_WRITE_ENABLE, 8'h00, 0);
    write_latch_flag = 1'b1;
    rd();
    wr(CMD_WRITE_STAT1, 8'h00, 8);
    write_latch_flag = 1'b0;
    rd();
    wr(CMD_WRITE_STAT1, 8'h80, 8);
    rd();
    wr(CMD_WRITE_ENABLE, 8'h00, 0);
    wr(CMD_WRITE_STAT1, 8'hbc, 8);
    lock = 1'b1;
    rd();
    wr(CMD_WRITE_ENABLE, 8'h00, 0);
    wr(CMD_WRITE_STAT1, 8'hbc, 8);
    @(posedge CLK);
    WP_N <= 1'b0;
    wr(CMD_WRITE_ENABLE, 8'h00, 0);
    wr(CMD_WRITE_STAT1, 8'h00, 8);
    rd();
    @(posedge CLK);
    WP_N <= 1'b1;
    wr(CMD_WRITE_ENABLE, 8'h00, 0);
    wr(CMD_WRITE_STAT1, 8'h00, 8);
    lock = 1'b0;
    rd();
    check(8'(gp_cnt), 8'h01, "global protect count");
    check(8'(gu_cnt), 8'h01, "global unprotect count");
    wr(CMD_WRITE_ENABLE, 8'h00, 0);
    wr(CMD_PROTECT, 8'h00, 0);
    wr(CMD_WRITE_ENABLE, 8'h00, 0);
    wr(CMD_WRITE_STAT2, 8'hff, 5);
    rd();
    wr(CMD_WRITE_ENABLE, 8'h00, 0);
    wr(CMD_WRITE_STAT2, 8'hff, 8);
    soft_reset_permit = 1'b1;
    lockdown_permit = 1'b1;
    rd();
    wr(CMD_WRITE_ENABLE, 8'h00, 0);
    wr(CMD_FREEZE, 8'h00, 0);
    lockdown_permit = 1'b0;
    rd();
    wr(CMD_WRITE_ENABLE, 8'h00, 0);
    wr(CMD_WRITE_STAT1, 8'h80, 8);
    lock = 1'b1;
    wr(CMD_SOFT_RESET, 8'h00, 0);
    rd();
    wr(CMD_WRITE_ENABLE, 8'h00, 0);
    wr(CMD_PROTECT, 8'h00, 0);
    check(8'(sp_cnt), 8'h01, "sector protect count");
    eng(1'b1, 1'b0);
    eng(1'b0, 1'b1);
    eng(1'b0, 1'b0);
    host.frame(CMD_READ_STATUS, 16'h0000, 3);
    #1;
    check({7'h00, so_oe}, 8'h00, "released output");
    end_of_test();
  end
endmodule
